// >>> asp_defines.svh
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_ADDR_W      11
`define ASP_DATA_W      8
`define ASP_WORDS       2048
`define ASP_CNT_W       4

`define ASP_CLK_NS      20
// slower grade figures: a controller timed for them serves both grades
`define ASP_T_ACC_NS    120
`define ASP_T_WP_NS     70
`define ASP_T_OHZ_NS    40
`define ASP_T_RC_NS     120
`define ASP_SYNC_STAGES 2

`define ASP_ACC_CYC  ((`ASP_T_ACC_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_WP_CYC   ((`ASP_T_WP_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_TURN_CYC ((`ASP_T_OHZ_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_REC_CYC  ((`ASP_T_RC_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)

`endif

// >>> asp_pkg.sv
`default_nettype none

package asp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WSET,
    ST_WPULSE,
    ST_WHOLD,
    ST_TURN,
    ST_RETAIN,
    ST_RECOVER
  } asp_state_e;
endpackage : asp_pkg

`default_nettype wire

// >>> asp_sync.sv
`default_nettype none

module asp_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        meta[i] <= 1'b0;
        q_o[i]  <= 1'b0;
      end else if (ce_i) begin
        meta[i] <= d_i[i];
        q_o[i]  <= meta[i];
      end
    end
  end

endmodule // asp_sync

`default_nettype wire

// >>> asp_host.sv
// How it works
// - a read: select and output drive low, read/write high, address steady.
// - a write needs select and read/write both low; here read/write pulses.
// - while select is high no address, write command or data is presented.
// - in low-voltage retention stay in standby, then wait the recovery time; here a cycle accepted before or with retain_i still runs to its end.
`include "asp_defines.svh"

`default_nettype none

module asp_host
  import asp_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   srst_i,
  input  wire logic                   ce_i,
  input  wire logic                   req_i,
  input  wire logic                   we_i,
  input  wire logic [`ASP_ADDR_W-1:0] addr_i,
  input  wire logic [`ASP_DATA_W-1:0] wdata_i,
  input  wire logic                   retain_i,
  output logic                        ready_o,
  output logic                        rvalid_o,
  output logic      [`ASP_DATA_W-1:0] rdata_o,
  output logic                        wdone_o,
  output logic      [`ASP_ADDR_W-1:0] address_lines_o,
  output logic                        dev_sel_n_o,
  output logic                        out_drv_n_o,
  output logic                        rd_wr_n_o,
  output logic      [`ASP_DATA_W-1:0] data_pins_o,
  output logic                        data_pins_oe_o,
  input  wire logic [`ASP_DATA_W-1:0] data_pins_i
);

  localparam logic [`ASP_CNT_W-1:0] RD_LOAD =
    `ASP_CNT_W'(`ASP_ACC_CYC + `ASP_SYNC_STAGES - 1);
  localparam logic [`ASP_CNT_W-1:0] WP_LOAD   = `ASP_CNT_W'(`ASP_WP_CYC - 1);
  localparam logic [`ASP_CNT_W-1:0] TURN_LOAD = `ASP_CNT_W'(`ASP_TURN_CYC - 1);
  localparam logic [`ASP_CNT_W-1:0] REC_LOAD  = `ASP_CNT_W'(`ASP_REC_CYC - 1);

  asp_state_e             state;
  asp_state_e             next_state;
  logic [`ASP_CNT_W-1:0]  cnt;
  logic [`ASP_CNT_W-1:0]  next_cnt;
  logic [`ASP_ADDR_W-1:0] areg;
  logic [`ASP_DATA_W-1:0] dreg;
  logic [`ASP_DATA_W-1:0] data_sync;

  wire take      = req_i & ready_o;
  wire cnt_zero  = (cnt == '0);
  wire [`ASP_ADDR_W-1:0] cur_addr = take ? addr_i : areg;
  wire [`ASP_DATA_W-1:0] cur_data = take ? wdata_i : dreg;

  // pin levels decoded from the coming state, then registered
  wire next_sel   = (next_state == ST_READ) | (next_state == ST_WSET) |
                    (next_state == ST_WPULSE) | (next_state == ST_WHOLD);
  wire next_drv   = (next_state == ST_READ);
  wire next_wr    = (next_state == ST_WPULSE);
  wire next_doe   = (next_state == ST_WSET) | (next_state == ST_WPULSE) |
                    (next_state == ST_WHOLD);
  wire next_ready = (next_state == ST_IDLE) & ~retain_i;
  wire read_done  = (state == ST_READ) & cnt_zero;
  wire write_done = (state == ST_WHOLD);

  asp_sync #(
    .WIDTH (`ASP_DATA_W)
  ) u_data_sync (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .d_i    (data_pins_i),
    .q_o    (data_sync)
  );

  always_comb begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - `ASP_CNT_W'(1);
    case (state)
      ST_IDLE: begin
        // an accepted request beats a retention request raised with it
        if (take) begin
          next_state = we_i ? ST_WSET : ST_READ;
          next_cnt   = RD_LOAD;
        end else if (retain_i) begin
          next_state = ST_RETAIN;
        end
      end
      ST_READ: begin
        if (cnt_zero) begin
          next_state = ST_TURN;
          next_cnt   = TURN_LOAD;
        end
      end
      ST_WSET: begin
        next_state = ST_WPULSE;
        next_cnt   = WP_LOAD;
      end
      ST_WPULSE: begin
        if (cnt_zero) begin
          next_state = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        next_state = ST_IDLE;
      end
      ST_TURN: begin
        // output drive off: let the memory float before anyone drives
        if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!retain_i) begin
          next_state = ST_RECOVER;
          next_cnt   = REC_LOAD;
        end
      end
      ST_RECOVER: begin
        if (retain_i) begin
          next_state = ST_RETAIN;
        end else if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
      areg  <= '0;
      dreg  <= '0;
    end else if (ce_i) begin
      state <= next_state;
      cnt   <= next_cnt;
      areg  <= cur_addr;
      dreg  <= cur_data;
    end
  end

  // static memory: pins simply rest between cycles, nothing to refresh
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dev_sel_n_o     <= 1'b1;
      out_drv_n_o     <= 1'b1;
      rd_wr_n_o       <= 1'b1;
      address_lines_o <= '0;
      data_pins_o     <= '0;
      data_pins_oe_o  <= 1'b0;
    end else if (ce_i) begin
      dev_sel_n_o     <= ~next_sel;
      out_drv_n_o     <= ~next_drv;
      rd_wr_n_o       <= ~next_wr;
      address_lines_o <= next_sel ? cur_addr : '0;
      data_pins_o     <= next_doe ? cur_data : '0;
      data_pins_oe_o  <= next_doe;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ready_o  <= 1'b0;
      rvalid_o <= 1'b0;
      wdone_o  <= 1'b0;
      rdata_o  <= '0;
    end else if (ce_i) begin
      ready_o  <= next_ready;
      rvalid_o <= read_done;
      wdone_o  <= write_done;
      if (read_done) begin
        rdata_o <= data_sync;
      end
    end
  end

  sequence write_pulse_s;
    !rd_wr_n_o [*4] ##1 rd_wr_n_o;
  endsequence

  sequence recover_s;
    !ready_o [*6];
  endsequence

  read_levels_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    !out_drv_n_o |-> !dev_sel_n_o && rd_wr_n_o && !data_pins_oe_o)
    else $error("read without select or with write asserted");

  write_window_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    !rd_wr_n_o |-> !dev_sel_n_o && out_drv_n_o && data_pins_oe_o)
    else $error("write strobe outside a driven selected cycle");

  pulse_width_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    $fell(rd_wr_n_o) |-> write_pulse_s)
    else $error("write pulse not four cycles");

  no_contention_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    data_pins_oe_o |-> out_drv_n_o && $past(out_drv_n_o)
                       && $past(out_drv_n_o, 2))
    else $error("host drives while memory may still drive");

  standby_quiet_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    dev_sel_n_o |-> address_lines_o == '0 && rd_wr_n_o && !data_pins_oe_o)
    else $error("activity on pins while deselected");

  retain_standby_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    (state == ST_RETAIN) |-> dev_sel_n_o && !ready_o)
    else $error("memory selected during retention");

  recover_wait_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    (state == ST_RETAIN && !retain_i) |=> recover_s)
    else $error("recovery time cut short");

  read_capture_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    $fell(out_drv_n_o) |-> !rvalid_o [*8] ##1 rvalid_o)
    else $error("read data not returned eight cycles after select");

  addr_stable_a: assert property (
    @(posedge mclk_i) disable iff (srst_i || !ce_i)
    !rd_wr_n_o && $past(!rd_wr_n_o) |-> $stable(address_lines_o))
    else $error("address moved inside the write window");

endmodule // asp_host

`default_nettype wire

// >>> asp_mem_model.sv
`default_nettype none

module asp_mem_model #(
  parameter int ACC_NS = 120
) (
  input  wire logic [10:0] address_lines_i,
  input  wire logic        dev_sel_n_i,
  input  wire logic        out_drv_n_i,
  input  wire logic        rd_wr_n_i,
  input  wire logic [7:0]  data_pins_i,
  output logic      [7:0]  q_o,
  output logic             drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // plain static array: no clock and no refresh anywhere
  logic [7:0]  mem [2048];
  logic [10:0] a_late;
  logic        rd_late;
  wire         wr = !dev_sel_n_i && !rd_wr_n_i;
  assign drv_o = !dev_sel_n_i && !out_drv_n_i && rd_wr_n_i;
  assign #(ACC_NS) a_late = address_lines_i;
  assign #(ACC_NS) rd_late = drv_o;
  // junk until address and enables are steady for the access time
  assign q_o = (drv_o && rd_late && a_late == address_lines_i) ?
               mem[address_lines_i] : ~mem[address_lines_i];
  always @(negedge wr) mem[address_lines_i] = data_pins_i;
endmodule // asp_mem_model

`default_nettype wire

// >>> asp_host_tb_top.sv
`default_nettype none

module asp_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 0, srst_i = 1, req_i = 0, we_i = 0, retain_i = 0;
  logic        ce_i = 1;
  logic [10:0] addr_i = '0, last_a = '0, a_o;
  logic [7:0]  wdata_i = '0, rdata_o, pins_o, pins_i, mem_q, q;
  logic        ready_o, rvalid_o, wdone_o, sel_n, drv_n, rw_n, oe, mem_drv;
  logic        both_prev = 0;
  int          mismatches = 0, compares = 0, n;

  always #10 mclk_i = ~mclk_i;
  // memory drives only when the host has let go, else its own junk
  assign pins_i = oe ? pins_o : mem_q;

  asp_host dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .req_i(req_i),
    .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .retain_i(retain_i),
    .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
    .wdone_o(wdone_o), .address_lines_o(a_o), .dev_sel_n_o(sel_n),
    .out_drv_n_o(drv_n), .rd_wr_n_o(rw_n), .data_pins_o(pins_o),
    .data_pins_oe_o(oe), .data_pins_i(pins_i));
  asp_mem_model #(.ACC_NS(120)) mem (.address_lines_i(a_o),
    .dev_sel_n_i(sel_n), .out_drv_n_i(drv_n), .rd_wr_n_i(rw_n),
    .data_pins_i(pins_i), .q_o(mem_q), .drv_o(mem_drv));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one byte per request; waits for the answer under a bound
  task automatic xfer(input logic w, input logic [10:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    int i;
    i = 0;
    while (ready_o !== 1'b1 && i < 20) begin
      @(negedge mclk_i);
      i++;
    end
    {req_i, we_i, addr_i, wdata_i} = {1'b1, w, a, d};
    @(negedge mclk_i);
    req_i = 0;
    i = 0;
    while ((w ? wdone_o : rvalid_o) !== 1'b1 && i < 14) begin
      @(negedge mclk_i);
      i++;
    end
    check(i < 14, 1);
    r = rdata_o;
  endtask

  // outside a cycle no address or data is presented; address steady while writing
  always @(negedge mclk_i) if (srst_i === 1'b0) begin
    if (sel_n === 1'b1) check({a_o, oe}, 0);
    if (both_prev && sel_n === 1'b0 && rw_n === 1'b0) check(a_o, last_a);
    check(mem_drv & oe, 0);
    both_prev = (sel_n === 1'b0 && rw_n === 1'b0);
    last_a = a_o;
  end

  task automatic t_rw();
    logic [10:0] al [3] = '{11'h000, 11'h7ff, 11'h2a5};
    logic [7:0]  dl [3] = '{8'h3c, 8'hc3, 8'h00};
    foreach (al[k]) xfer(1, al[k], dl[k], q);
    foreach (al[k]) begin
      xfer(0, al[k], 8'h00, q);
      check(q, dl[k]);
    end
    $display("t_rw done");
  endtask

  task automatic t_retain();
    xfer(1, 11'h007, 8'h5a, q);
    retain_i = 1;
    repeat (3) @(negedge mclk_i);
    check({ready_o, sel_n}, 2'b01);
    {req_i, we_i, addr_i, wdata_i} = {1'b1, 1'b1, 11'h007, 8'h11};
    repeat (4) @(negedge mclk_i);
    check({wdone_o, sel_n}, 2'b01);
    {req_i, retain_i} = 2'b00;
    n = 0;
    while (ready_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    // recovery must cover one full read cycle time
    check(n >= 6 && n < 20, 1);
    xfer(0, 11'h007, 8'h00, q);
    check(q, 8'h5a);
    $display("t_retain done");
  endtask

  // enable dropped in mid-read: pins must freeze, the read still lands
  task automatic t_stall();
    xfer(1, 11'h123, 8'h96, q);
    {req_i, we_i, addr_i} = {1'b1, 1'b0, 11'h123};
    @(negedge mclk_i);
    req_i = 0;
    @(negedge mclk_i);
    ce_i = 0;
    repeat (5) @(negedge mclk_i);
    check({sel_n, drv_n, rvalid_o, a_o}, {3'b000, 11'h123});
    ce_i = 1;
    n = 0;
    while (rvalid_o !== 1'b1 && n < 14) begin
      @(negedge mclk_i);
      n++;
    end
    check(n < 14, 1);
    check(rdata_o, 8'h96);
    $display("t_stall done");
  endtask

  initial begin
    repeat (3) @(negedge mclk_i);
    check({ready_o, sel_n, drv_n, rw_n, oe}, 5'b01110);
    srst_i = 0;
    t_rw();
    t_retain();
    t_stall();
    tally_and_finish();
  end

  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule // asp_host_tb_top

`default_nettype wire
